// >>> verilog/psr_core.sv
`timescale 1ns/1ps
module psr_core #(
	parameter bit HAS_MMU  = 1'b1,
	parameter bit HAS_MPU  = 1'b0,
	parameter bit HAS_EIC  = 1'b1,
	parameter int NUM_SETS = 4
)
(
	input  wire logic                        core_clk_i,
	input  wire logic                        reset_n_i,
	input  wire logic                        ctl_rd_i,
	input  wire logic                        ctl_wr_i,
	input  wire logic [31:0]                 ctl_wdata_i,
	output logic      [31:0]                 ctl_rdata_o,
	output logic                             ctl_fault_o,
	input  wire logic                        exc_take_i,
	input  wire logic                        exc_break_i,
	input  wire logic                        exc_ext_irq_i,
	input  wire logic                        exc_int_irq_i,
	input  wire logic                        exc_nmi_i,
	input  wire logic [psr_pkg::BANK_FW-1:0] exc_req_set_i,
	output logic      [31:0]                 saved_word_o,
	output psr_pkg::psr_save_t               saved_target_o,
	output logic                             saved_valid_o,
	input  wire logic                        req_ext_i,
	input  wire logic                        req_nmi_i,
	input  wire logic [psr_pkg::IL_FW-1:0]   req_level_i,
	input  wire logic [psr_pkg::BANK_FW-1:0] req_set_i,
	input  wire logic                        req_int_i,
	output logic                             ext_grant_o,
	output logic                             int_grant_o,
	input  wire logic                        tlb_miss_i,
	output logic                             tlb_fast_o,
	output logic                             tlb_double_o,
	output logic                             user_mode_o,
	output logic                             irq_enable_o,
	output logic      [psr_pkg::BANK_FW-1:0] bank_o
);
	import psr_pkg::*;

	// feature presence of each field
	localparam bit HAS_BANK = (NUM_SETS > 1); // [RL17]
	localparam bit HAS_BANK_IRQ_ENABLE = HAS_BANK && HAS_EIC;
	localparam bit HAS_EH   = HAS_MMU;
	localparam bit HAS_U    = HAS_MMU || HAS_MPU;
	localparam logic [BANK_FW-1:0] BMASK = psr_bank_mask(NUM_SETS); // [RL7]

	logic               bank_irq_enable_q;
	logic               nmi_q;
	logic [BANK_FW-1:0] prs_q;
	logic [BANK_FW-1:0] crs_q;
	logic [IL_FW-1:0]   il_q;
	logic               ih_q;
	logic               eh_q;
	logic               u_q;
	logic               pie_q;
	logic [31:0]        packed_word;
	logic               ext_ok;
	logic               int_ok;
	logic               wr_ok;
	logic               rd_ok;
	logic               prs_copy;
	logic               noint_exc;

	// a taken exception beats a control write in the same cycle
	assign wr_ok = ctl_wr_i && !u_q && !exc_take_i; // [RL20]
	assign rd_ok = ctl_rd_i && !u_q; // [RL20]
	assign noint_exc = exc_take_i && !exc_ext_irq_i && !exc_int_irq_i;
	assign prs_copy = exc_take_i && (!HAS_MMU || exc_break_i || !eh_q); // [RL5]

	psr_pack u_pack
	(
		.bank_irq_enable_i (bank_irq_enable_q),
		.nmi_i  (nmi_q),
		.prs_i  (prs_q),
		.crs_i  (crs_q),
		.il_i   (il_q),
		.ih_i   (ih_q),
		.eh_i   (eh_q),
		.u_i    (u_q),
		.pie_i  (pie_q),
		.word_o (packed_word)
	);

	psr_irq_gate #(
		.HAS_EIC (HAS_EIC)
	) u_gate
	(
		.pie_i       (pie_q),
		.bank_irq_enable_i      (bank_irq_enable_q),
		.il_i        (il_q),
		.crs_i       (crs_q),
		.req_ext_i   (req_ext_i),
		.req_nmi_i   (req_nmi_i),
		.req_level_i (req_level_i),
		.req_set_i   (req_set_i),
		.req_int_i   (req_int_i),
		.ext_ok_o    (ext_ok),
		.int_ok_o    (int_ok)
	);

	// absent fields keep their reset constant forever
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			bank_irq_enable_q <= RST_BANK_IRQ_ENABLE; // [RL2]
		else if (HAS_BANK_IRQ_ENABLE && wr_ok)
			bank_irq_enable_q <= ctl_wdata_i[BIT_BANK_IRQ_ENABLE]; // [RL18]
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			nmi_q <= RST_BIT; // [RL2]
		else if (HAS_EIC && exc_take_i && exc_ext_irq_i && exc_nmi_i)
			nmi_q <= 1'b1; // [RL4]
	end

	// saved word captures the old value in the same edge, so the copy precedes the bank update
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			prs_q <= RST_BANK;
		else if (HAS_BANK && prs_copy)
			prs_q <= crs_q; // [RL5] [RL6]
		else if (HAS_BANK && wr_ok)
			prs_q <= ctl_wdata_i[PRS_LSB +: BANK_FW] & BMASK; // [RL7] [RL8]
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			crs_q <= RST_BANK;
		else if (HAS_BANK && noint_exc)
			crs_q <= RST_BANK; // [RL9]
		else if (HAS_BANK && exc_take_i && exc_ext_irq_i)
			crs_q <= exc_req_set_i & BMASK; // [RL7]
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			il_q <= RST_IL;
		else if (HAS_EIC && wr_ok)
			il_q <= ctl_wdata_i[IL_LSB +: IL_FW];
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			ih_q <= RST_BIT;
		else if (HAS_EIC && exc_take_i && exc_ext_irq_i)
			ih_q <= 1'b1; // [RL11]
		else if (HAS_EIC && wr_ok)
			ih_q <= ctl_wdata_i[BIT_IH]; // [RL11]
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			eh_q <= RST_BIT;
		else if (HAS_EH && exc_take_i)
			eh_q <= 1'b1; // [RL12] [RL14]
		else if (HAS_EH && wr_ok)
			eh_q <= ctl_wdata_i[BIT_EH]; // [RL12] [RL19]
	end

	// handlers start in supervisor mode with interrupts off
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			u_q <= RST_BIT;
		else if (HAS_U && exc_take_i)
			u_q <= 1'b0; // [RL15]
		else if (HAS_U && wr_ok)
			u_q <= ctl_wdata_i[BIT_U]; // [RL15]
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			pie_q <= RST_BIT;
		else if (exc_take_i)
			pie_q <= 1'b0;
		else if (wr_ok)
			pie_q <= ctl_wdata_i[BIT_PIE]; // [RL16]
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			saved_word_o <= 32'h00000000;
			saved_target_o <= SAVE_NONE;
			saved_valid_o <= 1'b0;
		end
		else
		begin
			saved_valid_o <= exc_take_i;
			if (exc_take_i)
			begin
				saved_word_o <= packed_word; // [RL6]
				if (exc_break_i)
					saved_target_o <= SAVE_BRK;
				else if (exc_ext_irq_i && HAS_BANK && ((exc_req_set_i & BMASK) != RST_BANK))
					saved_target_o <= SAVE_SHADOW;
				else
					saved_target_o <= SAVE_EXC;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ctl_rdata_o <= 32'h00000000;
			ctl_fault_o <= 1'b0;
		end
		else
		begin
			ctl_fault_o <= (ctl_rd_i || ctl_wr_i) && u_q; // [RL20]
			if (rd_ok)
				ctl_rdata_o <= packed_word; // [RL21]
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ext_grant_o <= 1'b0;
			int_grant_o <= 1'b0;
			tlb_fast_o <= 1'b0;
			tlb_double_o <= 1'b0;
		end
		else
		begin
			ext_grant_o <= ext_ok; // [RL3] [RL10]
			int_grant_o <= int_ok; // [RL16]
			tlb_fast_o <= tlb_miss_i && !eh_q; // [RL13]
			tlb_double_o <= tlb_miss_i && eh_q; // [RL13]
		end
	end

	assign user_mode_o = u_q;
	assign irq_enable_o = pie_q;
	assign bank_o = crs_q;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	a_exc_sets_eh: assert property (exc_take_i && HAS_EH |=> eh_q) // [RL12]
		else $error("exception flag not set after exception");
	a_eh_absent_zero: assert property (!HAS_EH |-> !eh_q) // [RL14]
		else $error("exception flag set without memory management");
	a_crs_clear_noint: assert property (noint_exc |=> crs_q == RST_BANK) // [RL9]
		else $error("active bank not cleared on noninterrupt exception");
	a_prs_gets_crs: assert property (HAS_BANK && prs_copy |=> prs_q == $past(crs_q)) // [RL5]
		else $error("prior bank not copied from active bank");
	a_saved_old_word: assert property (exc_take_i |=> saved_valid_o
		&& saved_word_o == $past(packed_word)) // [RL6]
		else $error("saved word is not the pre-exception state");
	a_level_gate: assert property (ext_grant_o && !$past(req_nmi_i)
		|-> $past(req_level_i) > $past(il_q)) // [RL10]
		else $error("maskable grant at or below threshold");
	a_bank_irq_enable_gate: assert property (ext_grant_o && $past(req_set_i) == $past(crs_q)
		|-> $past(bank_irq_enable_q)) // [RL3]
		else $error("grant to current bank while bank enable is off");
	a_pie_gate: assert property (int_grant_o || (ext_grant_o && !$past(req_nmi_i))
		|-> $past(pie_q)) // [RL16]
		else $error("interrupt granted with global enable off");
	a_user_refused: assert property (ctl_wr_i && u_q && !exc_take_i
		|=> ctl_fault_o && $stable(packed_word)) // [RL20]
		else $error("user mode write changed state");
	a_nmi_sets: assert property (HAS_EIC && exc_take_i && exc_ext_irq_i && exc_nmi_i
		|=> nmi_q) // [RL4]
		else $error("nonmaskable flag not set");
	a_ih_sets: assert property (HAS_EIC && exc_take_i && exc_ext_irq_i |=> ih_q) // [RL11]
		else $error("handler flag not set on external interrupt");
	a_reserved_zero: assert property (ctl_rdata_o[31:RSV_LSB] == 8'h00) // [RL21]
		else $error("reserved bits read nonzero");
	a_bank_width: assert property (((crs_q | prs_q) & ~BMASK) == RST_BANK) // [RL7]
		else $error("unimplemented bank bits set");
	a_u_absent_zero: assert property (!HAS_U |-> !u_q) // [RL15]
		else $error("user bit set without memory management");
	a_bank_irq_enable_absent_one: assert property (!HAS_BANK_IRQ_ENABLE |-> bank_irq_enable_q) // [RL18]
		else $error("absent bank enable reads zero");
	// handlers must start with interrupts off, or a nested request could preempt the save
	a_exc_clears_pie: assert property (exc_take_i |=> !pie_q) // [RL16]
		else $error("global enable still set after exception");
	a_exc_clears_u: assert property (exc_take_i |=> !u_q) // [RL15]
		else $error("user mode still set after exception");
	a_crs_from_irq: assert property (HAS_BANK && exc_take_i && exc_ext_irq_i
		|=> crs_q == $past(exc_req_set_i & BMASK)) // [RL7]
		else $error("active bank not loaded from interrupt request");
	a_crs_kept_int: assert property (exc_take_i && exc_int_irq_i && !exc_ext_irq_i
		|=> $stable(crs_q)) // [RL9]
		else $error("active bank changed on internal interrupt");
	a_nmi_sticky: assert property (nmi_q |=> nmi_q) // [RL4]
		else $error("nonmaskable flag cleared");
	a_tlb_class: assert property (tlb_miss_i
		|=> tlb_double_o == $past(eh_q) && tlb_fast_o != $past(eh_q)) // [RL13]
		else $error("tlb miss misclassified");
	a_fault_user: assert property ((ctl_rd_i || ctl_wr_i) && u_q |=> ctl_fault_o) // [RL20]
		else $error("user mode access not faulted");
	a_rd_returns: assert property (rd_ok |=> ctl_rdata_o == $past(packed_word)) // [RL21]
		else $error("read data differs from state word");
	a_wr_lands_pie: assert property (wr_ok |=> pie_q == $past(ctl_wdata_i[BIT_PIE])) // [RL16]
		else $error("global enable write lost");
	a_saved_pulse: assert property (!exc_take_i |=> !saved_valid_o) // [RL6]
		else $error("saved valid without exception");
endmodule

// >>> inc/psr_pkg.sv
// What this block does
// RL1: fields packed high to low, bank_irq_enable at 23
// RL2: reset loads bank_irq_enable one, rest zero
// RL3: bank_irq_enable gates interrupts for current bank
// RL4: nonmaskable_active set on nonmaskable interrupt, read-only
// RL5: active bank copied to prior bank on exceptions; the code skips the copy while exception_active_flag is set, except on break
// RL6: save state word first, then copy bank
// RL7: bank fields only as wide as needed
// RL8: software writes only implemented bank numbers
// RL9: active bank read-only, cleared on noninterrupt exception
// RL10: maskable interrupt needs level above threshold
// RL11: handler_active_flag set on external interrupt
// RL12: exception_active_flag set on every exception
// RL13: tlb miss classed fast or double by flag
// RL14: no memory management holds exception flag zero
// RL15: privilege_select selects user mode, else zero
// RL16: global_irq_enable gates internal and maskable interrupts
// RL17: fields exist only with their configured features
// RL18: absent fields read constant, behave as held
// RL19: software never sets exception flag with user
// RL20: access only by control instructions in supervisor
// RL21: bits 31 to 24 read zero, writes ignored
package psr_pkg;
	localparam int BIT_BANK_IRQ_ENABLE = 23;
	localparam int BIT_NMI  = 22;
	localparam int PRS_LSB  = 16;
	localparam int CRS_LSB  = 10;
	localparam int IL_LSB   = 4;
	localparam int BIT_IH   = 3;
	localparam int BIT_EH   = 2;
	localparam int BIT_U    = 1;
	localparam int BIT_PIE  = 0;
	localparam int BANK_FW  = 6;
	localparam int IL_FW    = 6;
	localparam int RSV_LSB  = 24;

	localparam logic               RST_BANK_IRQ_ENABLE = 1'h1;
	localparam logic               RST_BIT  = 1'h0;
	localparam logic [BANK_FW-1:0] RST_BANK = 6'h00;
	localparam logic [IL_FW-1:0]   RST_IL   = 6'h00;

	typedef enum logic [1:0] {
		SAVE_NONE,
		SAVE_EXC,
		SAVE_BRK,
		SAVE_SHADOW
	} psr_save_t;

	// mask of the implemented bank bits for n register sets
	function automatic logic [BANK_FW-1:0] psr_bank_mask(input int n);
		int w;
		w = (n <= 1) ? 0 : $clog2(n);
		psr_bank_mask = BANK_FW'((1 << w) - 1);
	endfunction
endpackage

// >>> verilog/psr_pack.sv
`timescale 1ns/1ps
module psr_pack
(
	input  wire logic                       bank_irq_enable_i,
	input  wire logic                       nmi_i,
	input  wire logic [psr_pkg::BANK_FW-1:0] prs_i,
	input  wire logic [psr_pkg::BANK_FW-1:0] crs_i,
	input  wire logic [psr_pkg::IL_FW-1:0]   il_i,
	input  wire logic                       ih_i,
	input  wire logic                       eh_i,
	input  wire logic                       u_i,
	input  wire logic                       pie_i,
	output logic      [31:0]                word_o
);
	import psr_pkg::*;

	always_comb
	begin
		word_o = 32'h00000000; // [RL21]
		word_o[BIT_BANK_IRQ_ENABLE] = bank_irq_enable_i; // [RL1]
		word_o[BIT_NMI] = nmi_i;
		word_o[PRS_LSB +: BANK_FW] = prs_i;
		word_o[CRS_LSB +: BANK_FW] = crs_i;
		word_o[IL_LSB +: IL_FW] = il_i;
		word_o[BIT_IH] = ih_i;
		word_o[BIT_EH] = eh_i;
		word_o[BIT_U] = u_i;
		word_o[BIT_PIE] = pie_i;
	end
endmodule

// >>> verilog/psr_irq_gate.sv
`timescale 1ns/1ps
module psr_irq_gate #(
	parameter bit HAS_EIC = 1'b1
)
(
	input  wire logic                       pie_i,
	input  wire logic                       bank_irq_enable_i,
	input  wire logic [psr_pkg::IL_FW-1:0]   il_i,
	input  wire logic [psr_pkg::BANK_FW-1:0] crs_i,
	input  wire logic                       req_ext_i,
	input  wire logic                       req_nmi_i,
	input  wire logic [psr_pkg::IL_FW-1:0]   req_level_i,
	input  wire logic [psr_pkg::BANK_FW-1:0] req_set_i,
	input  wire logic                       req_int_i,
	output logic                            ext_ok_o,
	output logic                            int_ok_o
);
	import psr_pkg::*;

	logic bank_ok;

	always_comb
	begin
		bank_ok = (req_set_i != crs_i) || bank_irq_enable_i; // [RL3]
		ext_ok_o = 1'b0;
		int_ok_o = 1'b0;
		if (HAS_EIC)
		begin
			if (req_nmi_i)
				ext_ok_o = bank_ok;
			else
				ext_ok_o = req_ext_i && pie_i && (req_level_i > il_i) && bank_ok; // [RL10] [RL16]
		end
		else
			int_ok_o = req_int_i && pie_i; // [RL16]
	end
endmodule

// >>> dv/psr_core_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end
module psr_core_tb;
	import psr_pkg::*;
	logic        core_clk_i;
	logic        reset_n_i;
	logic        ctl_rd_i;
	logic        ctl_wr_i;
	logic [31:0] ctl_wdata_i;
	logic [31:0] ctl_rdata_o;
	logic        ctl_fault_o;
	logic        exc_take_i;
	logic        exc_break_i;
	logic        exc_ext_irq_i;
	logic        exc_int_irq_i;
	logic        exc_nmi_i;
	logic [5:0]  exc_req_set_i;
	logic [31:0] saved_word_o;
	psr_save_t   saved_target_o;
	logic        saved_valid_o;
	logic        req_ext_i;
	logic        req_nmi_i;
	logic [5:0]  req_level_i;
	logic [5:0]  req_set_i;
	logic        req_int_i;
	logic        ext_grant_o;
	logic        int_grant_o;
	logic        tlb_miss_i;
	logic        tlb_fast_o;
	logic        tlb_double_o;
	logic        user_mode_o;
	logic        irq_enable_o;
	logic [5:0]  bank_o;
	int          bad_count;
	int          comparisons;
	int          seed;
	int          bank_irq_enable, nmi, prior_bank_select, active_bank_select, il, ih, eh, u, global_irq_enable;
	logic [31:0] last_rd;

	psr_core #(.HAS_MMU(1'b1), .HAS_MPU(1'b0), .HAS_EIC(1'b1), .NUM_SETS(4)) i_dut (.*);

	// behavioural copy of the state word, four register sets
	function automatic logic [31:0] pk();
		return {8'h00, bank_irq_enable[0], nmi[0], 4'h0, prior_bank_select[1:0], 4'h0, active_bank_select[1:0], il[5:0],
			ih[0], eh[0], u[0], global_irq_enable[0]};
	endfunction

	task automatic m_reset();
		{nmi, prior_bank_select, active_bank_select, il, ih, eh, u, global_irq_enable} = '0;
		bank_irq_enable = 1;
		last_rd = 32'h00000000;
	endtask

	task automatic chk_outs();
		`CHK("user_mode", u[0], user_mode_o)
		`CHK("irq_enable", global_irq_enable[0], irq_enable_o)
		`CHK("bank", 6'(active_bank_select), bank_o)
	endtask

	task automatic do_rd();
		@(posedge core_clk_i);
		ctl_rd_i <= 1'b1;
		@(posedge core_clk_i);
		ctl_rd_i <= 1'b0;
		#1;
		if (u == 0)
			last_rd = pk();
		`CHK("rdata", last_rd, ctl_rdata_o)
		`CHK("rd_fault", u[0], ctl_fault_o)
	endtask

	task automatic do_wr(input logic [31:0] w);
		@(posedge core_clk_i);
		ctl_wr_i <= 1'b1;
		ctl_wdata_i <= w;
		@(posedge core_clk_i);
		ctl_wr_i <= 1'b0;
		#1;
		`CHK("wr_fault", u[0], ctl_fault_o)
		if (u == 0)
		begin
			bank_irq_enable = w[23];
			prior_bank_select = w[17:16];
			il = w[9:4];
			ih = w[3];
			eh = w[2];
			u = w[1];
			global_irq_enable = w[0];
		end
		chk_outs();
	endtask

	task automatic do_exc(input int k, input logic nm, input logic [5:0] st);
		logic [31:0] old;
		psr_save_t   tgt;
		old = pk();
		tgt = (k == 1) ? SAVE_BRK : ((k == 2 && st != 0) ? SAVE_SHADOW : SAVE_EXC);
		@(posedge core_clk_i);
		exc_take_i <= 1'b1;
		exc_break_i <= (k == 1);
		exc_ext_irq_i <= (k == 2);
		exc_int_irq_i <= (k == 3);
		exc_nmi_i <= nm && (k == 2);
		exc_req_set_i <= st;
		@(posedge core_clk_i);
		exc_take_i <= 1'b0;
		#1;
		`CHK("saved_valid", 1'b1, saved_valid_o)
		`CHK("saved_word", old, saved_word_o)
		`CHK("saved_target", tgt, saved_target_o)
		if (k == 1 || eh == 0)
			prior_bank_select = active_bank_select;
		eh = 1;
		u = 0;
		global_irq_enable = 0;
		if (k == 2)
			ih = 1;
		if (k == 2 && nm)
			nmi = 1;
		if (k < 2)
			active_bank_select = 0;
		if (k == 2)
			active_bank_select = st;
		chk_outs();
	endtask

	task automatic do_irq(input logic nm, input logic [5:0] lv, input logic [5:0] st);
		logic ex;
		ex = (nm || (global_irq_enable == 1 && lv > il)) && (st != active_bank_select || bank_irq_enable == 1);
		@(posedge core_clk_i);
		{req_ext_i, req_int_i, req_nmi_i} <= {2'b11, nm};
		req_level_i <= lv;
		req_set_i <= st;
		@(posedge core_clk_i);
		{req_ext_i, req_int_i, req_nmi_i} <= 3'b000;
		#1;
		`CHK("ext_grant", ex, ext_grant_o)
		`CHK("int_grant", 1'b0, int_grant_o)
	endtask

	task automatic do_tlb();
		@(posedge core_clk_i);
		tlb_miss_i <= 1'b1;
		@(posedge core_clk_i);
		tlb_miss_i <= 1'b0;
		#1;
		`CHK("tlb_fast", eh == 0, tlb_fast_o)
		`CHK("tlb_double", eh == 1, tlb_double_o)
	endtask

	task automatic do_reset();
		@(posedge core_clk_i);
		reset_n_i <= 1'b0;
		repeat (12) @(posedge core_clk_i);
		m_reset();
		#1;
		`CHK("rst_rdata", 32'h00000000, ctl_rdata_o)
		chk_outs();
		@(posedge core_clk_i);
		reset_n_i <= 1'b1;
		do_rd();
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end

	initial
	begin
		#(2000000);
		bad_count++;
		wrap_up();
	end

	initial
	begin
		logic [31:0] w;
		int          op;
		{reset_n_i, ctl_rd_i, ctl_wr_i, ctl_wdata_i, exc_take_i, exc_break_i} = '0;
		{exc_ext_irq_i, exc_int_irq_i, exc_nmi_i, exc_req_set_i} = '0;
		{req_ext_i, req_nmi_i, req_level_i, req_set_i, req_int_i, tlb_miss_i} = '0;
		bad_count = 0;
		comparisons = 0;
		seed = 57;
		do_reset();
		// nonmaskable flag and bits 31 to 24 set, top prior bank, threshold at maximum
		do_wr(32'hFFC303FD);
		do_rd();
		for (int i = 0; i < 600; i++)
		begin
			op = {$random(seed)} % 5;
			w = $random(seed);
			case (op)
				0:
				begin
					// keep the illegal exception-flag-plus-user combination and bad banks out
					w[21:18] = 4'h0;
					w[15:12] = 4'h0;
					if ({$random(seed)} % 4 != 0)
						w[1] = 1'b0;
					if (w[1])
						w[2] = 1'b0;
					do_wr(w);
				end
				1: do_rd();
				2: do_exc(w[1:0], w[2], {4'h0, w[5:4]});
				3: do_irq(w[0], 6'(il + {$random(seed)} % 3 - 1), {4'h0, w[5:4]});
				default: do_tlb();
			endcase
		end
		do_reset();
		wrap_up();
	end
endmodule
